// [rtl/rps_ctrl.sv]
// relay point selector controller with duplicated peripheral select bus interface
// assumes enable and address receiver pins synchronous to clk, idle high on enables
//
// Behaviour
// R1 - accept address from either select bus, chosen by which enable pulse arrives
// R2 - pulse the verify return lead of the enabled bus pair
// R3 - each code bit arrives as positive and negative wire, bits 00 to 36
// R4 - one-of-480 point selector; two form 960 points, normally split
// R5 - a 28-bit address selects exactly one latching relay
// R6 - the same address chooses operate or release signal
// R7 - armature movement clears selection enable and address register
// R8 - no new address registered or acted on until that clearing is done
// R9 - each controller serves 480 points; takes all 960 when mate fails
// R10 - receiver outputs idle high; a bit is a low-going pulse
// R11 - armature sense synchronised and edge detected before use
`timescale 1ns/100ps
`include "rps_regs.svh"

module rps_ctrl #(
  parameter logic CTRL_ID = 1'b0 // which half of the 960 points this controller owns
) (
  input wire logic clk, // system clock, 50 MHz
  input wire logic rstn, // async reset, active low
  input wire logic [1:0] enable_n, // enable pulse per bus, active low
  input wire rps_pkg::rps_bus_t ad_p0, // bus 0 code bits, positive wires
  input wire rps_pkg::rps_bus_t ad_n0, // bus 0 code bits, negative wires
  input wire rps_pkg::rps_bus_t ad_p1, // bus 1 code bits, positive wires
  input wire rps_pkg::rps_bus_t ad_n1, // bus 1 code bits, negative wires
  input wire logic mate_failed, // mate controller out of service
  input wire logic armature_moved, // relay armature movement sense
  output logic [1:0] verify_return_lead, // verify pulse per bus
  output logic [9:0] point_index, // selected relay point 0..959
  output logic point_active, // signal path established
  output logic point_operate, // send operate signal
  output logic point_release, // send release signal
  output logic busy // locked out awaiting armature
);
  import rps_pkg::*;

  localparam rps_cnt_t GATE_LAST = rps_cnt_t'(`RPS_GATE_CYC - 1);
  localparam rps_cnt_t POST_LAST = rps_cnt_t'(`RPS_POST_CYC - 1);
  localparam rps_cnt_t VSTART = rps_cnt_t'(`RPS_VSTART_CYC);
  localparam rps_cnt_t VEND = rps_cnt_t'(`RPS_VSTART_CYC + `RPS_VLEN_CYC);
  localparam logic [9:0] HALF = 10'(`RPS_HALF_POINTS);
  localparam logic [9:0] ALL = 10'(`RPS_ALL_POINTS);

  // ----------------------------------------
  // receivers
  // ----------------------------------------
  // receiver output per bit: idle high, low while the pair carries a pulse
  function automatic rps_bus_t rx_out_n(input rps_bus_t p, input rps_bus_t n);
    rx_out_n = ~(p & ~n);
  endfunction : rx_out_n

  rps_st_t r;
  rps_st_t next_r;
  rps_bus_t rx0_n;
  rps_bus_t rx1_n;
  rps_addr_t rx_addr;
  logic sense_rise;
  logic [9:0] dec_idx;
  logic dec_oper;
  logic dec_rel;
  logic dec_valid;
  logic in_range;
  logic close_gate;

  // R3 differential pairs
  assign rx0_n = rx_out_n(ad_p0, ad_n0);
  assign rx1_n = rx_out_n(ad_p1, ad_n1);

  // R1 selected bus path
  // R10 low-going bit pulse
  assign rx_addr = r.bus ? ~rx1_n[`RPS_ADDR_BITS-1:0] : ~rx0_n[`RPS_ADDR_BITS-1:0];

  // ----------------------------------------
  // armature sense
  // ----------------------------------------
  // R11 sync and edge
  rps_sync u_sense (
    .clk (clk),
    .rstn (rstn),
    .din (armature_moved),
    .rise (sense_rise)
  );

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    dec_idx = r.addr[`RPS_IDX_MSB:`RPS_IDX_LSB];
    dec_oper = r.addr[`RPS_OPER_BIT];
    dec_rel = r.addr[`RPS_REL_BIT];
    // R9 split or takeover
    if (mate_failed)
    begin
      in_range = dec_idx < ALL;
    end
    else if (CTRL_ID)
    begin
      in_range = (dec_idx >= HALF) && (dec_idx < ALL);
    end
    else
    begin
      in_range = dec_idx < HALF;
    end
    // R6 operate or release
    dec_valid = in_range && (dec_oper ^ dec_rel);
    close_gate = (r.gate_cnt == GATE_LAST) || (r.got_addr && (r.post_cnt == POST_LAST));

    // ----------------------------------------
    // verify return pulse
    // ----------------------------------------
    // R2 verify timing
    next_r.verify = 2'b00;
    if (r.vrun)
    begin
      next_r.vcnt = rps_cnt_t'(r.vcnt + 1'b1);
      if ((next_r.vcnt >= VSTART) && (next_r.vcnt < VEND))
      begin
        next_r.verify[r.vbus] = 1'b1;
      end
      if (next_r.vcnt >= VEND)
      begin
        next_r.vrun = 1'b0;
      end
    end

    // ----------------------------------------
    // selection sequence
    // ----------------------------------------
    unique case (r.state)
      RPS_IDLE:
      begin
        // R1 enable picks bus
        if (!enable_n[0] || !enable_n[1])
        begin
          next_r.state = RPS_GATE;
          next_r.bus = enable_n[0];
          next_r.vbus = enable_n[0];
          next_r.vrun = 1'b1;
          next_r.vcnt = '0;
          next_r.addr = '0;
          next_r.got_addr = 1'b0;
          next_r.gate_cnt = '0;
          next_r.post_cnt = '0;
        end
      end
      RPS_GATE:
      begin
        next_r.addr = r.addr | rx_addr;
        next_r.gate_cnt = rps_cnt_t'(r.gate_cnt + 1'b1);
        if (r.got_addr)
        begin
          next_r.post_cnt = rps_cnt_t'(r.post_cnt + 1'b1);
        end
        else if (|rx_addr)
        begin
          next_r.got_addr = 1'b1;
        end
        if (close_gate)
        begin
          // R5 one relay path
          // R4 one-of-480 selector
          if (dec_valid)
          begin
            next_r.state = RPS_HOLD;
            next_r.index = dec_idx;
            next_r.active = 1'b1;
            next_r.operate = dec_oper;
            next_r.release_sig = dec_rel;
          end
          else
          begin
            next_r.state = RPS_IDLE;
            next_r.addr = '0;
          end
        end
      end
      RPS_HOLD:
      begin
        // R8 enables ignored here
        // R7 armature clears
        if (sense_rise)
        begin
          next_r.state = RPS_IDLE;
          next_r.addr = '0;
          next_r.got_addr = 1'b0;
          next_r.active = 1'b0;
          next_r.operate = 1'b0;
          next_r.release_sig = 1'b0;
          next_r.index = '0;
        end
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r <= '{state: RPS_IDLE, default: '0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign verify_return_lead = r.verify;
  assign point_index = r.index;
  assign point_active = r.active;
  assign point_operate = r.operate;
  assign point_release = r.release_sig;
  assign busy = r.active;

endmodule : rps_ctrl

// [rtl/rps_regs.svh]
// timing counts and address field layout for the relay point selector controller
// assumes a single 50 MHz clock
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define RPS_CLK_NS 20

// ----------------------------------------
// bus timing, in ns as printed
// ----------------------------------------
`define RPS_GATE_NS 2200
`define RPS_POST_NS 400
`define RPS_VSTART_NS 2000
`define RPS_VLEN_NS 1000
`define RPS_PULSE_NS 500

// ----------------------------------------
// derived cycle counts
// ----------------------------------------
// longest times round down
`define RPS_GATE_CYC (`RPS_GATE_NS / `RPS_CLK_NS)
`define RPS_POST_CYC (`RPS_POST_NS / `RPS_CLK_NS)
// start and width of the verify pulse
`define RPS_VSTART_CYC (`RPS_VSTART_NS / `RPS_CLK_NS)
`define RPS_VLEN_CYC ((`RPS_VLEN_NS + `RPS_CLK_NS - 1) / `RPS_CLK_NS)
`define RPS_PULSE_CYC ((`RPS_PULSE_NS + `RPS_CLK_NS - 1) / `RPS_CLK_NS)

// ----------------------------------------
// address layout
// ----------------------------------------
`define RPS_BUS_BITS 37
`define RPS_ADDR_BITS 28
`define RPS_IDX_LSB 0
`define RPS_IDX_MSB 9
`define RPS_OPER_BIT 10
`define RPS_REL_BIT 11
`define RPS_HALF_POINTS 480
`define RPS_ALL_POINTS 960
`define RPS_CNT_W 8

`endif

// [rtl/rps_pkg.sv]
// types for the relay point selector controller
// assumes rps_regs.svh is on the include path
`include "rps_regs.svh"

package rps_pkg;

  // ----------------------------------------
  // controller states
  // ----------------------------------------
  typedef enum logic [1:0] {
    RPS_IDLE,
    RPS_GATE,
    RPS_HOLD
  } rps_state_t;

  typedef logic [`RPS_CNT_W-1:0] rps_cnt_t;
  typedef logic [`RPS_ADDR_BITS-1:0] rps_addr_t;
  typedef logic [`RPS_BUS_BITS-1:0] rps_bus_t;

  // ----------------------------------------
  // full controller state
  // ----------------------------------------
  typedef struct packed {
    rps_state_t state;
    logic bus;
    rps_addr_t addr;
    logic got_addr;
    rps_cnt_t gate_cnt;
    rps_cnt_t post_cnt;
    logic vrun;
    logic vbus;
    rps_cnt_t vcnt;
    logic [1:0] verify;
    logic [9:0] index;
    logic active;
    logic operate;
    logic release_sig;
  } rps_st_t;

  // ----------------------------------------
  // sense synchroniser state
  // ----------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic rise;
  } rps_sync_t;

endpackage : rps_pkg

// [rtl/rps_sync.sv]
// two-stage synchroniser with rising edge detect
// assumes the input may be asynchronous to clk
`timescale 1ns/100ps
`include "rps_regs.svh"

module rps_sync (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic din, // raw level
  output logic rise // one-cycle pulse on rising edge
);
  import rps_pkg::*;

  rps_sync_t r;
  rps_sync_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.meta = din;
    next_r.sync = r.meta;
    next_r.prev = r.sync;
    next_r.rise = r.sync & ~r.prev;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign rise = r.rise;

endmodule : rps_sync

// [sim/rps_sva.sv]
// port checker for rps_ctrl
// assumes bind onto rps_ctrl, one clock
`timescale 1ns/100ps
module rps_sva #(
  parameter logic CTRL_ID = 1'b0
) (
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic armature_moved, // sense
  input wire logic mate_failed, // mate out
  input wire logic [1:0] verify_return_lead, // verify
  input wire logic [9:0] point_index, // point
  input wire logic point_active, // held
  input wire logic point_operate, // operate
  input wire logic point_release, // release
  input wire logic busy // lockout
);
  logic [7:0] vlen;
  logic [9:0] lo;
  assign lo = CTRL_ID ? 10'h1E0 : 10'h000;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      vlen <= 8'h00;
    else
      vlen <= (|verify_return_lead) ? vlen + 8'h01 : 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_BUSY: assert property (busy == point_active)
    else $error("busy mismatch");
  AST_ONE_CMD: assert property (point_active |-> point_operate != point_release)
    else $error("command mismatch");
  AST_IDLE_OUT: assert property (!point_active |-> !point_operate && !point_release &&
    point_index == 10'h000)
    else $error("idle outputs");
  AST_VER_ONE: assert property (verify_return_lead != 2'b11)
    else $error("both verify");
  AST_VER_LEN: assert property ($fell(|verify_return_lead) |-> vlen == 8'h32)
    else $error("verify width");
  AST_RANGE: assert property ($rose(point_active) |-> point_index < 10'h3C0 &&
    (mate_failed || (point_index >= lo && point_index < lo + 10'h1E0)))
    else $error("point range");
  AST_CLEAR: assert property ($rose(armature_moved) && point_active |=>
    point_active ##[1:4] !point_active)
    else $error("clear timing");
  AST_LOCK: assert property (point_active && $past(point_active) |-> $stable(point_index))
    else $error("point changed");
  AST_FALL: assert property ($fell(point_active) |-> $past(armature_moved, 2))
    else $error("early clear");
  cover property ($rose(point_active) && point_operate);
  cover property ($rose(point_active) && point_release);
  cover property ($fell(verify_return_lead[1]));
endmodule : rps_sva
bind rps_ctrl rps_sva #(.CTRL_ID(CTRL_ID)) u_sva (.clk(clk), .rstn(rstn),
  .armature_moved(armature_moved), .mate_failed(mate_failed),
  .verify_return_lead(verify_return_lead), .point_index(point_index),
  .point_active(point_active), .point_operate(point_operate),
  .point_release(point_release), .busy(busy));

// [sim/rps_relay.sv]
// latching relay model behind rps_ctrl
// assumes point_active marks a held path
`timescale 1ns/100ps
module rps_relay #(
  parameter int DLY = 250 // cycles to armature movement
) (
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic point_active, // path held
  output logic armature_moved // sense
);
  int cnt;
  always @(posedge clk or negedge rstn)
    if (!rstn || !point_active)
    begin
      cnt <= 0;
      armature_moved <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 1;
      if (cnt == DLY)
        armature_moved <= 1'b1;
    end
endmodule : rps_relay

// [sim/test_relay_point_selector_ctrl.sv]
// self-checking bench for rps_ctrl
// assumes rps_relay on far side, rps_sva bound
`timescale 1ns/100ps
module test_relay_point_selector_ctrl;
  import rps_pkg::*;
  logic clk, rstn, mate_failed, armature_moved, point_active, point_operate, point_release, busy;
  logic [1:0] enable_n, verify_return_lead;
  logic [9:0] point_index;
  logic armature1, active1, operate1, release1, busy1;
  logic [1:0] verify1;
  logic [9:0] index1;
  rps_bus_t ad_p0, ad_n0, ad_p1, ad_n1;
  int n_fail = 0, n_checks = 0, cyc = 0;
  rps_ctrl dut_u (.clk(clk), .rstn(rstn), .enable_n(enable_n), .ad_p0(ad_p0), .ad_n0(ad_n0),
    .ad_p1(ad_p1), .ad_n1(ad_n1), .mate_failed(mate_failed), .armature_moved(armature_moved),
    .verify_return_lead(verify_return_lead), .point_index(point_index),
    .point_active(point_active), .point_operate(point_operate),
    .point_release(point_release), .busy(busy));
  rps_relay far_u (.clk(clk), .rstn(rstn), .point_active(point_active),
    .armature_moved(armature_moved));
  // mate controller owns the upper half of the points
  rps_ctrl #(.CTRL_ID(1'b1)) dut_mate_u (.clk(clk), .rstn(rstn), .enable_n(enable_n),
    .ad_p0(ad_p0), .ad_n0(ad_n0), .ad_p1(ad_p1), .ad_n1(ad_n1), .mate_failed(mate_failed),
    .armature_moved(armature1), .verify_return_lead(verify1), .point_index(index1),
    .point_active(active1), .point_operate(operate1), .point_release(release1),
    .busy(busy1));
  rps_relay far_mate_u (.clk(clk), .rstn(rstn), .point_active(active1),
    .armature_moved(armature1));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic accept(input logic [9:0] idx, input logic o, r, mf, hi);
    return (o != r) && (idx < 10'h3C0) && (mf || (hi == (idx >= 10'h1E0)));
  endfunction : accept
  // selected bus carries a or idle pairs, other bus a decoy
  task automatic put(input logic b, input logic [27:0] a, input logic on);
    rps_bus_t p, n, d;
    d = rps_bus_t'({$urandom, $urandom});
    p = {d[36:28], on ? a : d[27:0]};
    n = on ? {d[36:28], ~a} : p;
    ad_p0 = b ? d : p;
    ad_n0 = b ? ~d : n;
    ad_p1 = b ? p : d;
    ad_n1 = b ? n : ~d;
  endtask : put
  task automatic op(input logic b, input logic [9:0] idx, input logic o, r, mf, both, poke);
    int k;
    logic ok;
    logic ok1;
    logic take1;
    ok = accept(idx, o, r, mf, 1'b0);
    ok1 = accept(idx, o, r, mf, 1'b1);
    take1 = !ok1 && accept(~idx, 1'b1, 1'b0, mf, 1'b1);
    mate_failed = mf;
    enable_n = both ? 2'b00 : (b ? 2'b01 : 2'b10);
    @(posedge clk);
    #1;
    enable_n = 2'b11;
    put(b, {16'h0000, r, o, idx}, 1'b1);
    k = 0;
    while (verify_return_lead === 2'b00 && k < 300)
    begin
      @(posedge clk);
      #1;
      k++;
      if (k == 25)
        put(b, 28'h0000000, 1'b0);
    end
    chk(10'(k), 10'h064);
    chk(10'(verify_return_lead), b ? 10'h002 : 10'h001);
    chk(10'(point_active), 10'(ok));
    chk(point_index, ok ? idx : 10'h000);
    chk(10'({point_operate, point_release}), ok ? 10'({o, r}) : 10'h000);
    chk(10'(verify1), b ? 10'h002 : 10'h001);
    chk(10'({active1, operate1, release1}), ok1 ? 10'({1'b1, o, r}) : 10'h000);
    chk(index1, ok1 ? idx : 10'h000);
    if (poke && ok)
    begin
      repeat (60) @(posedge clk);
      #1;
      enable_n = 2'b10;
      put(1'b0, {16'h0000, 2'b01, ~idx}, 1'b1);
      @(posedge clk);
      #1;
      enable_n = 2'b11;
      repeat (30) @(posedge clk);
      #1;
      chk(point_index, idx);
      chk(index1, ok1 ? idx : (take1 ? ~idx : 10'h000));
      put(1'b0, 28'h0000000, 1'b0);
    end
    k = 0;
    while ((busy !== 1'b0 || verify_return_lead !== 2'b00 || busy1 !== 1'b0 ||
      verify1 !== 2'b00) && k < 600)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(10'(busy), 10'h000);
    chk(10'({busy1, verify1}), 10'h000);
    repeat (5) @(posedge clk);
    #1;
    $display("test point %0d done", idx);
  endtask : op
  initial
  begin
    void'($urandom(32'h4900));
    rstn = 1'b0;
    enable_n = 2'b11;
    mate_failed = 1'b0;
    put(1'b0, 28'h0000000, 1'b0);
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(posedge clk);
    #1;
    chk(10'({busy, verify_return_lead, busy1, verify1}), 10'h000);
    chk(point_index | index1, 10'h000);
    op(1'b0, 10'h1DF, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    op(1'b1, 10'h1E0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    op(1'b1, 10'h3BF, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    op(1'b0, 10'h3C0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    op(1'b0, 10'h000, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    op(1'b0, 10'h005, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    repeat (14)
      op(1'($urandom), 10'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'b0, 1'b1);
    complete_run();
  end
endmodule : test_relay_point_selector_ctrl
